// >>> pcc_pkg.sv
// shared constants and carrier types of the packet and activity-detect config block
package pcc_pkg;
   // *****************************************
   // clocking and timing
   // *****************************************
   localparam int CLK_PERIOD_NS = 25;
   localparam int HOLD_UNIT_NS  = 15625;  // one unit of receive hold time
   localparam int HOLD_UNIT_CYC = HOLD_UNIT_NS / CLK_PERIOD_NS;
   // *****************************************
   // command opcodes
   // *****************************************
   localparam logic [7:0] OP_FRAME   = 8'h8c;
   localparam logic [7:0] OP_DETECT  = 8'h88;
   localparam logic [7:0] OP_BUFBASE = 8'ha0;
   localparam logic [7:0] OP_SYMVAL  = 8'ha1;
   localparam logic [3:0] CMD_BYTES  = 4'ha;  // opcode plus nine parameters
   localparam logic [3:0] DET_BYTES  = 4'h8;
   localparam logic [3:0] BUF_BYTES  = 4'h3;
   localparam logic [3:0] SYM_BYTES  = 4'h2;
   // *****************************************
   // register indices (byte address = index * 4)
   // *****************************************
   localparam logic [11:0] IDX_SEED_HI = 12'h6b8;
   localparam logic [11:0] IDX_SEED_LO = 12'h6b9;
   localparam logic [11:0] IDX_CTRL    = 12'h700;
   localparam logic [11:0] IDX_STATUS  = 12'h701;
   localparam logic [11:0] IDX_FRAME0  = 12'h702;
   localparam logic [11:0] IDX_FRAME1  = 12'h703;
   localparam logic [11:0] IDX_DET0    = 12'h704;
   localparam logic [11:0] IDX_DET1    = 12'h705;
   localparam logic [11:0] IDX_BUF     = 12'h706;
   localparam logic [11:0] IDX_SYM     = 12'h707;
   localparam logic [7:0]  SEED_HI_RST = 8'h01;
   localparam logic [7:0]  SEED_LO_RST = 8'h00;
   localparam int CTRL_CHIRP = 0;  // packet type: 1 chirp, 0 gfsk
   localparam int CTRL_DET   = 1;  // write 1 starts activity detection
   localparam int CTRL_RX    = 2;  // write 1 arms symbol validation
   localparam int STAT_TMO   = 0;  // sticky receive timeout, write 1 clears
   // *****************************************
   // field encodings
   // *****************************************
   localparam logic [7:0] HDR_EXPLICIT = 8'h00;
   localparam logic [7:0] FLAG_ON      = 8'h01;
   localparam logic [7:0] EXIT_STBY    = 8'h00;
   localparam logic [7:0] EXIT_RX      = 8'h01;
   localparam logic [7:0] SYM_CODE_MAX = 8'h04;
   localparam logic [1:0] RESP_OK      = 2'b00;
   localparam logic [1:0] RESP_SLVERR  = 2'b10;
   // *****************************************
   // carriers
   // *****************************************
   typedef struct packed {
      logic [15:0] preamble;
      logic        implicit_hdr;
      logic [7:0]  payload_len;
      logic        crc_en;
      logic        iq_invert;
      logic        whiten_en;
   } pcc_frame_t;
   typedef struct packed {
      logic [4:0]  symbols;
      logic [7:0]  peak;
      logic [7:0]  floor_thr;
      logic [7:0]  exit_action;
      logic [23:0] hold_time;
   } pcc_detect_t;
endpackage : pcc_pkg

// >>> pcc_config.sv
// command decoder, register slave and detect/validate sequencing
`timescale 1ns/1ps
module pcc_config
   import pcc_pkg::*;
#(
   parameter int ADDR_W = 14
) (
   input  wire logic               clock,
   input  wire logic               srst,
   input  wire logic [ADDR_W-1:0]  s_axi_awaddr,
   input  wire logic               s_axi_awvalid,
   output logic                    s_axi_awready,
   input  wire logic [31:0]        s_axi_wdata,
   input  wire logic [3:0]         s_axi_wstrb,
   input  wire logic               s_axi_wvalid,
   output logic                    s_axi_wready,
   output logic [1:0]              s_axi_bresp,
   output logic                    s_axi_bvalid,
   input  wire logic               s_axi_bready,
   input  wire logic [ADDR_W-1:0]  s_axi_araddr,
   input  wire logic               s_axi_arvalid,
   output logic                    s_axi_arready,
   output logic [31:0]             s_axi_rdata,
   output logic [1:0]              s_axi_rresp,
   output logic                    s_axi_rvalid,
   input  wire logic               s_axi_rready,
   input  wire logic               spi_sck,
   input  wire logic               spi_mosi,
   input  wire logic               spi_nss_n,
   input  wire logic               cad_done,
   input  wire logic               cad_hit,
   input  wire logic               pkt_detected,
   input  wire logic               symbol_seen,
   input  wire logic               demod_locked,
   output pcc_pkg::pcc_frame_t     frame_cfg_r,
   output pcc_pkg::pcc_detect_t    detect_cfg_r,
   output logic [7:0]              tx_base_r,
   output logic [7:0]              rx_base_r,
   output logic                    chirp_mode_r,
   output logic                    header_insert_r,
   output logic                    cad_active_r,
   output logic                    rx_hold_r,
   output logic                    standby_req_r,
   output logic                    rx_valid_r,
   output logic                    receive_timeout_event_r
);
   import pcc_pkg::*;

   generate
      if (ADDR_W < 14) begin : g_chk
         $error("pcc_config: ADDR_W must be at least 14");
      end
   endgenerate

   // *****************************************
   // serial command port
   // *****************************************
   logic [2:0] sck_s_r, nss_s_r;   // two sync stages plus edge history
   logic [1:0] mosi_s_r;
   logic [7:0] shift_r;            // incoming byte, msb first
   logic [2:0] bit_r;
   logic [3:0] cnt_r;              // bytes taken this frame
   logic [7:0] bytes_r [0:9];      // opcode and parameters
   logic       cmd_end;            // frame closed by select release
   logic       sck_rise;

   // sync pins; only stage [1] and later feed logic
   always_ff @(posedge clock) begin
      if (srst) begin
         sck_s_r  <= 3'h0;
         nss_s_r  <= 3'h7;
         mosi_s_r <= 2'h0;
      end else begin
         sck_s_r  <= {sck_s_r[1:0], spi_sck};
         nss_s_r  <= {nss_s_r[1:0], spi_nss_n};
         mosi_s_r <= {mosi_s_r[0], spi_mosi};
      end
   end

   assign sck_rise = sck_s_r[1] & ~sck_s_r[2] & ~nss_s_r[1];
   assign cmd_end  = nss_s_r[1] & ~nss_s_r[2];

   // assemble bytes on sampling edges; extra bytes past ten are dropped
   always_ff @(posedge clock) begin
      if (srst) begin
         shift_r <= 8'h00;
         bit_r   <= 3'h0;
         cnt_r   <= 4'h0;
         for (int i = 0; i < 10; i++) bytes_r[i] <= 8'h00;
      end else if (~nss_s_r[1] & nss_s_r[2]) begin
         bit_r <= 3'h0;
         cnt_r <= 4'h0;
      end else if (sck_rise) begin
         shift_r <= {shift_r[6:0], mosi_s_r[1]};
         bit_r   <= bit_r + 3'h1;
         if (bit_r == 3'h7 && cnt_r < CMD_BYTES) begin
            bytes_r[cnt_r] <= {shift_r[6:0], mosi_s_r[1]};
            cnt_r          <= cnt_r + 4'h1;
         end
      end
   end

   // *****************************************
   // register bus
   // *****************************************
   logic [ADDR_W-1:0] waddr_r, raddr;
   logic [31:0]       wdata_r;
   logic              aw_held_r, w_held_r, wr_go;
   logic [7:0]        seed_hi_r, seed_lo_r;
   logic              tmo_sticky_r;
   logic [7:0]        sym_count_r;   // validation symbol count
   logic [31:0]       rd_val;
   logic              rd_hit;

   assign s_axi_awready = ~aw_held_r & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held_r & ~s_axi_bvalid;
   assign wr_go         = aw_held_r & w_held_r & ~s_axi_bvalid;
   assign s_axi_arready = ~s_axi_rvalid;
   assign raddr         = s_axi_araddr;

   // write address and data may arrive in either order
   always_ff @(posedge clock) begin
      if (srst) begin
         aw_held_r    <= 1'b0;
         w_held_r     <= 1'b0;
         waddr_r      <= '0;
         wdata_r      <= 32'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held_r <= 1'b1;
            waddr_r   <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
         end
         if (wr_go) begin
            aw_held_r    <= 1'b0;
            w_held_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (waddr_r[ADDR_W-1:2] inside {IDX_SEED_HI, IDX_SEED_LO,
                             IDX_CTRL, IDX_STATUS}) ? RESP_OK : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // read mux; unmapped reads return zero with slverr
   always_comb begin
      rd_hit = 1'b1;
      case (raddr[ADDR_W-1:2])
         IDX_SEED_HI: rd_val = {24'h0, seed_hi_r};
         IDX_SEED_LO: rd_val = {24'h0, seed_lo_r};
         IDX_CTRL:    rd_val = {31'h0, chirp_mode_r};
         IDX_STATUS:  rd_val = {28'h0, rx_hold_r, cad_active_r, rx_valid_r, tmo_sticky_r};
         IDX_FRAME0:  rd_val = {7'h0, frame_cfg_r.implicit_hdr, frame_cfg_r.payload_len,
                                frame_cfg_r.preamble};
         IDX_FRAME1:  rd_val = {29'h0, frame_cfg_r.crc_en, frame_cfg_r.iq_invert,
                                frame_cfg_r.whiten_en};
         IDX_DET0:    rd_val = {3'h0, detect_cfg_r.symbols, detect_cfg_r.peak,
                                detect_cfg_r.floor_thr, detect_cfg_r.exit_action};
         IDX_DET1:    rd_val = {8'h0, detect_cfg_r.hold_time};
         IDX_BUF:     rd_val = {16'h0, tx_base_r, rx_base_r};
         IDX_SYM:     rd_val = {24'h0, sym_count_r};
         default: begin
            rd_val = 32'h0;
            rd_hit = 1'b0;
         end
      endcase
   end

   // one read outstanding; answer one cycle after address
   always_ff @(posedge clock) begin
      if (srst) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0;
         s_axi_rresp  <= RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_val;
         s_axi_rresp  <= rd_hit ? RESP_OK : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   logic wr_seed_hi, wr_seed_lo, wr_ctrl, wr_stat;
   logic s_axi_wstrb_q0;   // low byte lane of the held write
   assign wr_seed_hi = wr_go && waddr_r[ADDR_W-1:2] == IDX_SEED_HI && s_axi_wstrb_q0;
   assign wr_seed_lo = wr_go && waddr_r[ADDR_W-1:2] == IDX_SEED_LO && s_axi_wstrb_q0;
   assign wr_ctrl    = wr_go && waddr_r[ADDR_W-1:2] == IDX_CTRL && s_axi_wstrb_q0;
   assign wr_stat    = wr_go && waddr_r[ADDR_W-1:2] == IDX_STATUS && s_axi_wstrb_q0;

   // lane enable is captured with the data so a late address still sees it
   always_ff @(posedge clock) begin
      if (srst) s_axi_wstrb_q0 <= 1'b0;
      else if (s_axi_wvalid && s_axi_wready) s_axi_wstrb_q0 <= s_axi_wstrb[0];
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         seed_hi_r    <= SEED_HI_RST;
         seed_lo_r    <= SEED_LO_RST;
         chirp_mode_r <= 1'b0;
      end else begin
         if (wr_seed_hi) seed_hi_r <= wdata_r[7:0];
         if (wr_seed_lo) seed_lo_r <= wdata_r[7:0];
         if (wr_ctrl) chirp_mode_r <= wdata_r[CTRL_CHIRP];
      end
   end

   // *****************************************
   // command decode
   // *****************************************
   logic is_frame, is_det, is_buf, is_sym;
   assign is_frame = cmd_end && bytes_r[0] == OP_FRAME;
   assign is_det   = cmd_end && bytes_r[0] == OP_DETECT && cnt_r == DET_BYTES;
   assign is_buf   = cmd_end && bytes_r[0] == OP_BUFBASE && cnt_r == BUF_BYTES;
   assign is_sym   = cmd_end && bytes_r[0] == OP_SYMVAL && cnt_r == SYM_BYTES;

   // parameters taken only when actually sent
   always_ff @(posedge clock) begin
      if (srst) begin
         frame_cfg_r <= '0;
      end else if (is_frame) begin
         if (!chirp_mode_r) begin
            if (cnt_r == CMD_BYTES) frame_cfg_r.whiten_en <= bytes_r[9] == FLAG_ON;
         end else begin
            if (cnt_r > 4'h2) frame_cfg_r.preamble <= {bytes_r[1], bytes_r[2]};
            if (cnt_r > 4'h3) frame_cfg_r.implicit_hdr <= bytes_r[3] != HDR_EXPLICIT;
            if (cnt_r > 4'h4) frame_cfg_r.payload_len <= bytes_r[4];
            if (cnt_r > 4'h5) frame_cfg_r.crc_en <= bytes_r[5] == FLAG_ON;
            if (cnt_r > 4'h6) frame_cfg_r.iq_invert <= bytes_r[6] == FLAG_ON;
         end
      end
   end

   // header insertion for explicit chirp frames
   always_ff @(posedge clock) begin
      if (srst) header_insert_r <= 1'b0;
      else header_insert_r <= chirp_mode_r & ~frame_cfg_r.implicit_hdr;
   end

   // detect setup layout; short frames ignored
   always_ff @(posedge clock) begin
      if (srst) begin
         detect_cfg_r <= '0;
         detect_cfg_r.symbols <= 5'h01;
      end else if (is_det) begin
         // code to symbol count; out-of-range codes clamp to 16
         detect_cfg_r.symbols <= (bytes_r[1] > SYM_CODE_MAX) ? 5'h10 :
                                 5'(5'h01 << bytes_r[1][2:0]);
         // thresholds go straight to the correlator
         detect_cfg_r.peak        <= bytes_r[2];
         detect_cfg_r.floor_thr   <= bytes_r[3];
         detect_cfg_r.exit_action <= bytes_r[4];
         detect_cfg_r.hold_time   <= {bytes_r[5], bytes_r[6], bytes_r[7]};
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         tx_base_r   <= 8'h00;
         rx_base_r   <= 8'h00;
         sym_count_r <= 8'h00;
      end else begin
         if (is_buf) begin
            tx_base_r <= bytes_r[1];
            rx_base_r <= bytes_r[2];
         end
         if (is_sym) sym_count_r <= bytes_r[1];
      end
   end

   // *****************************************
   // activity detect sequencer
   // *****************************************
   typedef enum logic [1:0] {DS_IDLE, DS_DETECT, DS_HOLD} pcc_det_state_t;
   pcc_det_state_t det_st_r;
   logic [9:0]     unit_cnt_r;   // cycles inside one hold unit
   logic [23:0]    hold_left_r;  // hold units remaining

   always_ff @(posedge clock) begin
      if (srst) begin
         det_st_r      <= DS_IDLE;
         cad_active_r  <= 1'b0;
         rx_hold_r     <= 1'b0;
         standby_req_r <= 1'b0;
         unit_cnt_r    <= 10'h0;
         hold_left_r   <= 24'h0;
      end else begin
         standby_req_r <= 1'b0;
         case (det_st_r)
            DS_IDLE: begin
               if (wr_ctrl && wdata_r[CTRL_DET]) begin
                  det_st_r     <= DS_DETECT;
                  cad_active_r <= 1'b1;
               end
            end
            DS_DETECT: begin
               if (cad_done) begin
                  cad_active_r <= 1'b0;
                  // hold time only counts on receive exit with a hit
                  if (detect_cfg_r.exit_action == EXIT_RX && cad_hit) begin
                     det_st_r    <= DS_HOLD;
                     rx_hold_r   <= 1'b1;
                     unit_cnt_r  <= 10'h0;
                     hold_left_r <= detect_cfg_r.hold_time;
                  end else begin
                     // back to standby whatever was seen
                     det_st_r      <= DS_IDLE;
                     standby_req_r <= 1'b1;
                  end
               end
            end
            DS_HOLD: begin
               // leave on packet or when hold units run out
               if (pkt_detected || hold_left_r == 24'h0) begin
                  det_st_r  <= DS_IDLE;
                  rx_hold_r <= 1'b0;
                  standby_req_r <= ~pkt_detected;
               end else if (unit_cnt_r == 10'(HOLD_UNIT_CYC - 1)) begin
                  unit_cnt_r  <= 10'h0;
                  hold_left_r <= hold_left_r - 24'h1;
               end else begin
                  unit_cnt_r <= unit_cnt_r + 10'h1;
               end
            end
            default: det_st_r <= DS_IDLE;
         endcase
      end
   end

   // *****************************************
   // reception validation
   // *****************************************
   logic       rx_armed_r;
   logic [7:0] sym_seen_r;   // symbols counted since arming

   // odd host counts are not trapped; counting just runs to the value
   always_ff @(posedge clock) begin
      if (srst) begin
         rx_armed_r <= 1'b0;
         sym_seen_r <= 8'h00;
         rx_valid_r <= 1'b0;
         receive_timeout_event_r <= 1'b0;
      end else begin
         rx_valid_r <= 1'b0;
         receive_timeout_event_r <= 1'b0;
         if (wr_ctrl && wdata_r[CTRL_RX]) begin
            rx_armed_r <= 1'b1;
            sym_seen_r <= 8'h00;
         end else if (rx_armed_r && symbol_seen) begin
            if (sym_count_r == 8'h00) begin
               rx_valid_r <= 1'b1;
               rx_armed_r <= 1'b0;
            end else if (sym_seen_r + 8'h01 == sym_count_r) begin
               // judge lock after the last symbol
               rx_valid_r <= demod_locked;
               receive_timeout_event_r <= ~demod_locked;
               rx_armed_r <= 1'b0;
            end else begin
               sym_seen_r <= sym_seen_r + 8'h01;
            end
         end
      end
   end

   // sticky timeout; a new event beats a same-cycle clear
   always_ff @(posedge clock) begin
      if (srst) tmo_sticky_r <= 1'b0;
      else if (receive_timeout_event_r) tmo_sticky_r <= 1'b1;
      else if (wr_stat && wdata_r[STAT_TMO]) tmo_sticky_r <= 1'b0;
   end

   // *****************************************
   // assertions
   // *****************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);

   a_frame_preamble: assert property (is_frame && chirp_mode_r && cnt_r > 4'h2 |=>
      frame_cfg_r.preamble == $past({bytes_r[1], bytes_r[2]})) else $error("preamble not taken");
   a_whiten_sel: assert property (is_frame && !chirp_mode_r && cnt_r == CMD_BYTES |=>
      frame_cfg_r.whiten_en == ($past(bytes_r[9]) == FLAG_ON)) else $error("whitening wrong");
   a_seed_reset: assert property (disable iff (1'b0) srst |=>
      seed_hi_r == SEED_HI_RST && seed_lo_r == SEED_LO_RST) else $error("seed reset wrong");
   a_hdr_insert: assert property (chirp_mode_r && !frame_cfg_r.implicit_hdr &&
      $stable(chirp_mode_r) |=> header_insert_r) else $error("header not inserted");
   a_sym_decode: assert property (is_det && bytes_r[1] <= SYM_CODE_MAX |=>
      detect_cfg_r.symbols == 5'h01 << $past(bytes_r[1][2:0])) else $error("symbol decode");
   a_exit_stby: assert property (det_st_r == DS_DETECT && cad_done &&
      detect_cfg_r.exit_action == EXIT_STBY |=> standby_req_r && det_st_r == DS_IDLE)
      else $error("no standby");
   a_hold_unit: assert property (det_st_r == DS_HOLD && !pkt_detected && hold_left_r != 24'h0
      && unit_cnt_r == 10'h0 |-> ##[1:625] hold_left_r != $past(hold_left_r) || !rx_hold_r)
      else $error("hold unit too long");
   a_hold_gate: assert property (det_st_r == DS_DETECT && cad_done &&
      detect_cfg_r.exit_action != EXIT_RX |=> !rx_hold_r) else $error("hold without rx exit");
   a_buf_base: assert property (is_buf |=>
      tx_base_r == $past(bytes_r[1]) && rx_base_r == $past(bytes_r[2])) else $error("base");
   a_first_sym: assert property (rx_armed_r && symbol_seen && sym_count_r == 8'h00
      && !wr_ctrl |=> rx_valid_r ##1 !rx_valid_r) else $error("no instant valid");
   a_rx_timeout: assert property (rx_armed_r && symbol_seen && !wr_ctrl &&
      sym_count_r != 8'h00 && sym_seen_r + 8'h01 == sym_count_r && !demod_locked |=>
      receive_timeout_event_r && !rx_valid_r) else $error("no receive timeout");
   a_keep_cfg: assert property (!is_det |=> $stable(detect_cfg_r)) else $error("cfg drift");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");

   c_hold_exit: cover property (det_st_r == DS_HOLD ##1 det_st_r == DS_IDLE);
   c_timeout: cover property (receive_timeout_event_r);
   c_frame_full: cover property (is_frame && cnt_r == CMD_BYTES);
   c_bad_read: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : pcc_config

// >>> pcc_host.sv
// partner model: host that sends serial commands
`timescale 1ns/1ps
module pcc_host (
   output logic spi_sck,
   output logic spi_mosi,
   output logic spi_nss_n
);
   initial {spi_sck, spi_mosi, spi_nss_n} = 3'b001;
   task automatic send(input logic [7:0] q[$]);
      spi_nss_n = 1'b0;
      foreach (q[i]) for (int b = 7; b >= 0; b--) begin
         #100 spi_sck = 1'b0;
         spi_mosi = q[i][b];
         #100 spi_sck = 1'b1;
      end
      #100 spi_sck = 1'b0;
      #100 spi_nss_n = 1'b1;
      // released line must not look like held data
      spi_mosi = ~spi_mosi;
      #200;
   endtask : send
endmodule : pcc_host

// >>> tb_pcc_config.sv
// bench of the packet and activity-detect config block
`timescale 1ns/1ps
module tb_pcc_config;
   import pcc_pkg::*;
   logic clock = 1'b0, srst = 1'b1;
   logic [13:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, spi_sck, spi_mosi, spi_nss_n;
   logic cad_done, cad_hit, pkt_detected = 1'b0, symbol_seen, demod_locked = 1'b0;
   logic chirp_mode_r, header_insert_r, cad_active_r, rx_hold_r, standby_req_r, rx_valid_r, receive_timeout_event_r;
   pcc_frame_t frame_cfg_r;
   pcc_detect_t detect_cfg_r;
   logic [7:0] tx_base_r, rx_base_r, pk;
   logic [15:0] pre;
   logic [4:0] t;
   logic [33:0] expq[$];
   int n_fail = 0, num_checks = 0, n_stby = 0, n_val = 0, n_tmo = 0;
   pcc_config i_dut (.*);
   pcc_host i_host (.spi_sck(spi_sck), .spi_mosi(spi_mosi), .spi_nss_n(spi_nss_n));
   initial forever #12.5 clock = ~clock;
   initial {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready,
            s_axi_arvalid, s_axi_rready, cad_done, cad_hit, symbol_seen} = '0;
   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR %0t: got %h want %h", $time, got, exp);
      end
   endtask : chk
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish
   // one bus cycle; each source drops when its partner was seen ready
   task automatic bus(input logic wr, input logic [11:0] idx, input logic [31:0] d);
      if (wr) {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {idx, 2'b00, d, 3'b111};
      else {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {idx, 2'b00, 2'b11};
      do begin
         @(negedge clock);
         t = {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid};
         @(posedge clock);
         {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <=
            {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} & ~t;
      end while (|({s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} & ~t));
      @(posedge clock);
   endtask : bus
   task automatic det;
      bus(1, IDX_CTRL, 32'h3);
      repeat (3) @(posedge clock);
      {cad_done, cad_hit} <= 2'b11;
      @(posedge clock);
      {cad_done, cad_hit} <= 2'b00;
      repeat (3) @(posedge clock);
   endtask : det
   // read data compared at the handshake, oldest note first
   always @(negedge clock) if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1)
      chk({s_axi_rresp, s_axi_rdata}, expq.pop_front());
   always @(posedge clock) begin
      n_stby += int'(standby_req_r === 1'b1);
      n_val += int'(rx_valid_r === 1'b1);
      n_tmo += int'(receive_timeout_event_r === 1'b1);
   end
   initial begin
      #1_000_000;
      n_fail++;
      tally_and_finish;
   end
   initial begin
      void'($urandom(71552));
      repeat (4) @(posedge clock);
      srst <= 1'b0;
      @(posedge clock);
      pk = 8'($urandom);
      expq = '{{RESP_OK, 24'h0, SEED_HI_RST}, {RESP_OK, 24'h0, SEED_LO_RST}, {RESP_OK, 24'h0, pk}, {RESP_SLVERR, 32'h0}};
      bus(0, IDX_SEED_HI, '0);
      bus(0, IDX_SEED_LO, '0);
      bus(1, IDX_SEED_LO, {24'h0, pk});
      bus(0, IDX_SEED_LO, '0);
      bus(0, 12'h010, '0);
      bus(1, IDX_CTRL, 32'h1);
      pre = 16'($urandom_range(65535, 1));
      i_host.send('{OP_FRAME, pre[15:8], pre[7:0], HDR_EXPLICIT, pk, FLAG_ON, FLAG_ON});
      repeat (8) @(posedge clock);
      chk({frame_cfg_r[27:1], header_insert_r}, {pre, 1'b0, pk, 3'b111});
      i_host.send('{OP_FRAME, 8'h00, 8'h01, 8'h01, pk, 8'h00, 8'h00});
      repeat (8) @(posedge clock);
      chk({frame_cfg_r[27:1], header_insert_r}, {16'h1, 1'b1, pk, 3'b000});
      bus(1, IDX_CTRL, 32'h0);
      i_host.send('{OP_FRAME, 8'h0, 8'h1, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, 8'h0, FLAG_ON});
      repeat (8) @(posedge clock);
      chk(frame_cfg_r.whiten_en, 1'b1);
      for (int c = 0; c < 5; c++) begin
         i_host.send('{OP_DETECT, 8'(c), pk, ~pk, 8'(c == 4), 8'h0, 8'h0, 8'h2});
         repeat (8) @(posedge clock);
         chk(detect_cfg_r, {5'(1 << c), pk, ~pk, 8'(c == 4), 24'h2});
         if (c == 0) det;
         if (c == 0) chk({rx_hold_r, 8'(n_stby)}, 9'h001);
      end
      det;
      repeat (1240) @(posedge clock);
      chk({rx_hold_r, 8'(n_stby)}, 9'h101);
      repeat (20) @(posedge clock);
      chk({rx_hold_r, 8'(n_stby)}, 9'h002);
      i_host.send('{OP_BUFBASE, pk, ~pk});
      repeat (8) @(posedge clock);
      chk({tx_base_r, rx_base_r, frame_cfg_r.preamble}, {pk, ~pk, 16'h1});
      // only legal counts: zero, then four
      for (int n = 0; n < 5; n += 4) begin
         i_host.send('{OP_SYMVAL, 8'(n)});
         repeat (8) @(posedge clock);
         bus(1, IDX_CTRL, 32'h5);
         repeat (n + int'(n == 0)) begin
            symbol_seen <= 1'b1;
            @(posedge clock);
            symbol_seen <= 1'b0;
            repeat (3) @(posedge clock);
         end
         chk({8'(n_val), 8'(n_tmo)}, {8'h1, 8'(n / 4)});
      end
      tally_and_finish;
   end
endmodule : tb_pcc_config
